// ---- rtl/obcd_top.sv ----
/*
 * Option byte configuration decoder: captures three option bytes
 * at reset release, decodes oscillator, wakeup and pin remap
 * settings, times crystal settling and exposes all over APB.
 * Assumes option bytes are stable around reset release and the
 * oscillator input is synchronous to the core clock.
 */
`timescale 1ns/1ns

// Behaviour
// - Clock type 0 crystal, 1 driven input
// - Wakeup source 0 low-speed RC, 1 prescaled external
// - Prescaler 0x 16MHz, 10 8MHz, 11 4MHz
// - Settle code 00 waits 2048 cycles
// - Settle code b4 waits 128 cycles
// - Settle d2 eight cycles, e1 half cycle
// - Cleared remap bit keeps default functions
// - Option seven: C3, C4 timer complements
// - Option six: D7 timer channel four
// - Option five: D0 main clock output
// - Option four: B4 trigger, B5 break
// - Option three: top-level interrupt on pin
// - Option two: C4, D2 analog, D4 serial clock
module obcd_top
   import obcd_pkg::*;
(
   // Clock and reset
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_RESET,
   // APB slave
   input  wire logic              I_PSEL,
   input  wire logic              I_PENABLE,
   input  wire logic              I_PWRITE,
   input  wire logic [ADDR_W-1:0] I_PADDR,
   input  wire logic [31:0]       I_PWDATA,
   output      logic [31:0]       O_PRDATA,
   output      logic              O_PREADY,
   output      logic              O_PSLVERR,
   // Option bytes
   input  wire logic [7:0]        I_OPT_PIN_REMAP,
   input  wire logic [7:0]        I_OPT_CLOCK_WAKEUP,
   input  wire logic [7:0]        I_OPT_CRYSTAL_SETTLE,
   // Oscillator
   input  wire logic              I_EXT_HIGH_SPEED_OSC,
   output      logic              O_XTAL_DRIVE_EN,
   output      logic              O_OSC_BYPASS,
   output      logic              O_OSC_READY,
   // Wakeup unit
   output      logic              O_WAKEUP_SRC_EXT,
   output      logic [13:0]       O_WAKEUP_SRC_KHZ,
   // Pin alternate function selects
   output      logic              O_PC3_ADV_TIMER_CH1_COMPLEMENT,
   output      logic              O_PC4_ADV_TIMER_CH2_COMPLEMENT,
   output      logic              O_PD7_ADV_TIMER_CHANNEL_FOUR,
   output      logic              O_PD0_MAIN_CLOCK_OUTPUT,
   output      logic              O_PB4_CONVERTER_EXT_TRIGGER,
   output      logic              O_PB5_ADV_TIMER_BREAK_INPUT,
   output      logic              O_TOP_LEVEL_IRQ_INPUT,
   output      logic              O_PC4_ANALOG_INPUT_TWO,
   output      logic              O_PD2_ANALOG_INPUT_THREE,
   output      logic              O_PD4_SERIAL_SYNC_CLOCK
);

   // ****************************************************
   // Capture at reset release
   // ****************************************************
   logic             captured_q;
   logic [7:0]       option_pin_remap;
   logic [7:0]       option_clock_wakeup;
   logic [7:0]       option_crystal_settle;

   // Straps are caught by the clock after release, never by the reset itself
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         captured_q <= 1'b0;
      end else begin
         captured_q <= 1'b1;
      end
   end

   obcd_capture_reg #(
      .W (8)
   ) u_cap_remap (
      .i_clk  (I_CORE_CLK),
      .i_rst  (I_RESET),
      .i_load (!captured_q),
      .i_d    (I_OPT_PIN_REMAP),
      .o_q    (option_pin_remap)
   );

   obcd_capture_reg #(
      .W (8)
   ) u_cap_clock (
      .i_clk  (I_CORE_CLK),
      .i_rst  (I_RESET),
      .i_load (!captured_q),
      .i_d    (I_OPT_CLOCK_WAKEUP),
      .o_q    (option_clock_wakeup)
   );

   obcd_capture_reg #(
      .W (8)
   ) u_cap_settle (
      .i_clk  (I_CORE_CLK),
      .i_rst  (I_RESET),
      .i_load (!captured_q),
      .i_d    (I_OPT_CRYSTAL_SETTLE),
      .o_q    (option_crystal_settle)
   );

   // ****************************************************
   // Field decode
   // ****************************************************
   logic             ext_clock_type_sel;
   logic             wakeup_clock_source_sel;
   logic [1:0]       wakeup_prescaler_sel;
   logic [7:0]       crystal_settle_count;
   logic [CNT_W-1:0] settle_target;
   logic             settle_code_odd;
   logic [13:0]      wakeup_khz;
   logic             remap_conflict;

   assign ext_clock_type_sel      = option_clock_wakeup[EXT_CLOCK_BIT];
   assign wakeup_clock_source_sel = option_clock_wakeup[WAKEUP_SRC_BIT];
   assign wakeup_prescaler_sel    = option_clock_wakeup[PRESC_HI_BIT:PRESC_LO_BIT];
   assign crystal_settle_count    = option_crystal_settle;

   // Unlisted codes fall back to the longest wait, the safe side
   always_comb begin
      settle_code_odd = 1'b0;
      case (crystal_settle_count)
         SETTLE_CODE_2048: settle_target = HALF_EDGES_2048;
         SETTLE_CODE_128:  settle_target = HALF_EDGES_128;
         SETTLE_CODE_8:    settle_target = HALF_EDGES_8;
         SETTLE_CODE_HALF: settle_target = HALF_EDGES_HALF;
         default: begin
            settle_target   = HALF_EDGES_2048;
            settle_code_odd = 1'b1;
         end
      endcase
   end

   always_comb begin
      case (wakeup_prescaler_sel)
         2'h2:    wakeup_khz = WAKEUP_KHZ_8M;
         2'h3:    wakeup_khz = WAKEUP_KHZ_4M;
         default: wakeup_khz = WAKEUP_KHZ_16M;
      endcase
   end

   // Port C: seven, two. Port D: six, five, two. Flagged, not blocked.
   assign remap_conflict =
      (option_pin_remap[REMAP_SEVEN_BIT] && option_pin_remap[REMAP_TWO_BIT]) ||
      (option_pin_remap[REMAP_SIX_BIT] && option_pin_remap[REMAP_FIVE_BIT]) ||
      (option_pin_remap[REMAP_SIX_BIT] && option_pin_remap[REMAP_TWO_BIT]) ||
      (option_pin_remap[REMAP_FIVE_BIT] && option_pin_remap[REMAP_TWO_BIT]);

   // ****************************************************
   // Oscillator and settle timing
   // ****************************************************
   logic             osc_en_q;
   logic             settle_done;

   obcd_settle_counter u_settle (
      .i_clk    (I_CORE_CLK),
      .i_rst    (I_RESET),
      .i_enable (osc_en_q && captured_q),
      .i_osc    (I_EXT_HIGH_SPEED_OSC),
      .i_target (settle_target),
      .o_done   (settle_done)
   );

   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_XTAL_DRIVE_EN <= 1'b0;
         O_OSC_BYPASS    <= 1'b0;
         O_OSC_READY     <= 1'b0;
      end else begin
         O_XTAL_DRIVE_EN <= osc_en_q && captured_q && !ext_clock_type_sel;
         O_OSC_BYPASS    <= captured_q && ext_clock_type_sel;
         O_OSC_READY     <= settle_done && osc_en_q;
      end
   end

   // ****************************************************
   // Wakeup clock selection
   // ****************************************************
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_WAKEUP_SRC_EXT <= 1'b0;
         O_WAKEUP_SRC_KHZ <= WAKEUP_KHZ_16M;
      end else begin
         O_WAKEUP_SRC_EXT <= wakeup_clock_source_sel;
         O_WAKEUP_SRC_KHZ <= wakeup_khz;
      end
   end

   // ****************************************************
   // Pin remap selects
   // ****************************************************
   // A cleared bit leaves each select low, i.e. default function
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_PC3_ADV_TIMER_CH1_COMPLEMENT <= 1'b0;
         O_PC4_ADV_TIMER_CH2_COMPLEMENT <= 1'b0;
         O_PD7_ADV_TIMER_CHANNEL_FOUR   <= 1'b0;
         O_PD0_MAIN_CLOCK_OUTPUT        <= 1'b0;
         O_PB4_CONVERTER_EXT_TRIGGER    <= 1'b0;
         O_PB5_ADV_TIMER_BREAK_INPUT    <= 1'b0;
         O_TOP_LEVEL_IRQ_INPUT          <= 1'b0;
         O_PC4_ANALOG_INPUT_TWO         <= 1'b0;
         O_PD2_ANALOG_INPUT_THREE       <= 1'b0;
         O_PD4_SERIAL_SYNC_CLOCK        <= 1'b0;
      end else begin
         O_PC3_ADV_TIMER_CH1_COMPLEMENT <= option_pin_remap[REMAP_SEVEN_BIT];
         O_PC4_ADV_TIMER_CH2_COMPLEMENT <= option_pin_remap[REMAP_SEVEN_BIT];
         O_PD7_ADV_TIMER_CHANNEL_FOUR   <= option_pin_remap[REMAP_SIX_BIT];
         O_PD0_MAIN_CLOCK_OUTPUT        <= option_pin_remap[REMAP_FIVE_BIT];
         O_PB4_CONVERTER_EXT_TRIGGER    <= option_pin_remap[REMAP_FOUR_BIT];
         O_PB5_ADV_TIMER_BREAK_INPUT    <= option_pin_remap[REMAP_FOUR_BIT];
         O_TOP_LEVEL_IRQ_INPUT          <= option_pin_remap[REMAP_THREE_BIT];
         O_PC4_ANALOG_INPUT_TWO         <= option_pin_remap[REMAP_TWO_BIT];
         O_PD2_ANALOG_INPUT_THREE       <= option_pin_remap[REMAP_TWO_BIT];
         O_PD4_SERIAL_SYNC_CLOCK        <= option_pin_remap[REMAP_TWO_BIT];
      end
   end

   // ****************************************************
   // APB slave
   // ****************************************************
   logic             access;
   logic             hit;
   logic [31:0]      read_word;

   // One wait state: pready rises on the second access cycle
   assign access = I_PSEL && I_PENABLE && !O_PREADY;

   always_comb begin
      hit       = 1'b1;
      read_word = 32'h0;
      case (I_PADDR)
         OFS_PIN_REMAP:      read_word[7:0] = option_pin_remap;
         OFS_CLOCK_WAKEUP:   read_word[7:0] = option_clock_wakeup;
         OFS_CRYSTAL_SETTLE: read_word[7:0] = option_crystal_settle;
         OFS_CONTROL:        read_word[CTL_OSC_EN_BIT] = osc_en_q;
         OFS_STATUS: begin
            read_word[STS_OSC_READY_BIT]  = O_OSC_READY;
            read_word[STS_CAPTURED_BIT]   = captured_q;
            read_word[STS_CONFLICT_BIT]   = remap_conflict;
            read_word[STS_SETTLE_ODD_BIT] = settle_code_odd;
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA  <= 32'h0;
      end else begin
         O_PREADY  <= access;
         O_PSLVERR <= access && !hit;
         O_PRDATA  <= (access && !I_PWRITE) ? read_word : 32'h0;
      end
   end

   // Only the control word is writable; option bytes stay read-only
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         osc_en_q <= 1'b0;
      end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && (I_PADDR == OFS_CONTROL)) begin
         osc_en_q <= I_PWDATA[CTL_OSC_EN_BIT];
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   sequence s_captured;
      captured_q ##1 captured_q;
   endsequence

   sequence s_apb_access;
      I_PSEL && I_PENABLE && !O_PREADY;
   endsequence

   hold_after_capture_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      s_captured |-> $stable(option_pin_remap) && $stable(option_clock_wakeup)
                     && $stable(option_crystal_settle))
      else $error("option bytes changed after capture");

   crystal_drive_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      s_captured |-> O_OSC_BYPASS == ext_clock_type_sel
                     && (O_XTAL_DRIVE_EN -> !ext_clock_type_sel))
      else $error("oscillator mode disagrees with clock type");

   wakeup_source_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      s_captured |-> O_WAKEUP_SRC_EXT == option_clock_wakeup[WAKEUP_SRC_BIT])
      else $error("wakeup source select wrong");

   wakeup_presc_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      s_captured ##0 (wakeup_prescaler_sel == 2'h3) |-> O_WAKEUP_SRC_KHZ == WAKEUP_KHZ_4M)
      else $error("prescaler 11 must assume 4 MHz");

   settle_long_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (crystal_settle_count == SETTLE_CODE_2048) |-> settle_target == HALF_EDGES_2048)
      else $error("code 00 must wait 2048 cycles");

   settle_short_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      (crystal_settle_count == SETTLE_CODE_128) |-> settle_target == HALF_EDGES_128)
      else $error("code b4 must wait 128 cycles");

   remap_map_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      s_captured |-> O_PD4_SERIAL_SYNC_CLOCK == option_pin_remap[REMAP_TWO_BIT]
                     && O_PC3_ADV_TIMER_CH1_COMPLEMENT == option_pin_remap[REMAP_SEVEN_BIT])
      else $error("remap select disagrees with option byte");

   ready_needs_enable_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      !osc_en_q |=> !O_OSC_READY)
      else $error("oscillator ready while disabled");

   ready_after_done_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      $rose(O_OSC_READY) |-> $past(settle_done) && $past(osc_en_q))
      else $error("oscillator ready without full settle count");

   apb_answer_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RESET)
      s_apb_access |=> O_PREADY ##1 !O_PREADY)
      else $error("apb answer not one cycle after access");

endmodule

// ---- rtl/obcd_pkg.sv ----
/*
 * Shared constants for the option byte configuration decoder:
 * register map, option byte field layout, settle counts and
 * wakeup source frequencies.
 * Assumes a 32-bit APB register bus and a 100 MHz core clock.
 */
package obcd_pkg;

   // ****************************************************
   // Register map (byte addresses)
   // ****************************************************
   localparam int          ADDR_W              = 12;
   localparam logic [11:0] OFS_PIN_REMAP       = 12'h000;
   localparam logic [11:0] OFS_CLOCK_WAKEUP    = 12'h004;
   localparam logic [11:0] OFS_CRYSTAL_SETTLE  = 12'h008;
   localparam logic [11:0] OFS_CONTROL         = 12'h00c;
   localparam logic [11:0] OFS_STATUS          = 12'h010;

   // ****************************************************
   // Control and status bits
   // ****************************************************
   localparam int          CTL_OSC_EN_BIT      = 0;
   localparam int          STS_OSC_READY_BIT   = 0;
   localparam int          STS_CAPTURED_BIT    = 1;
   localparam int          STS_CONFLICT_BIT    = 2;
   localparam int          STS_SETTLE_ODD_BIT  = 3;

   // ****************************************************
   // Option byte fields
   // ****************************************************
   localparam int          EXT_CLOCK_BIT       = 3;
   localparam int          WAKEUP_SRC_BIT      = 2;
   localparam int          PRESC_HI_BIT        = 1;
   localparam int          PRESC_LO_BIT        = 0;
   localparam int          REMAP_SEVEN_BIT     = 7;
   localparam int          REMAP_SIX_BIT       = 6;
   localparam int          REMAP_FIVE_BIT      = 5;
   localparam int          REMAP_FOUR_BIT      = 4;
   localparam int          REMAP_THREE_BIT     = 3;
   localparam int          REMAP_TWO_BIT       = 2;

   // ****************************************************
   // Crystal settle codes and waits in half oscillator cycles
   // ****************************************************
   localparam int          CNT_W               = 13;
   localparam logic [7:0]  SETTLE_CODE_2048    = 8'h00;
   localparam logic [7:0]  SETTLE_CODE_128     = 8'hb4;
   localparam logic [7:0]  SETTLE_CODE_8       = 8'hd2;
   localparam logic [7:0]  SETTLE_CODE_HALF    = 8'he1;
   localparam logic [12:0] HALF_EDGES_2048     = 13'h1000;
   localparam logic [12:0] HALF_EDGES_128      = 13'h0100;
   localparam logic [12:0] HALF_EDGES_8        = 13'h0010;
   localparam logic [12:0] HALF_EDGES_HALF     = 13'h0001;

   // ****************************************************
   // Assumed wakeup source frequency in kHz
   // ****************************************************
   localparam logic [13:0] WAKEUP_KHZ_16M      = 14'h3e80;
   localparam logic [13:0] WAKEUP_KHZ_8M       = 14'h1f40;
   localparam logic [13:0] WAKEUP_KHZ_4M       = 14'h0fa0;

endpackage

// ---- rtl/obcd_capture_reg.sv ----
/*
 * One-shot capture register: takes its input while load is high
 * and holds it otherwise.
 * Assumes load is high for exactly one cycle after reset release.
 */
`timescale 1ns/1ns
module obcd_capture_reg #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Capture
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_d,
   output      logic [W-1:0] o_q
);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_q <= '0;
      end else if (i_load) begin
         o_q <= i_d;
      end
   end

endmodule

// ---- rtl/obcd_settle_counter.sv ----
/*
 * Oscillator settle counter: counts both edges of the oscillator
 * input while enabled and raises done once the target is reached.
 * Assumes the oscillator input is synchronous to the core clock
 * and at most half its rate.
 */
`timescale 1ns/1ns
module obcd_settle_counter
   import obcd_pkg::*;
(
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Control
   input  wire logic             i_enable,
   input  wire logic             i_osc,
   input  wire logic [CNT_W-1:0] i_target,
   // Result
   output      logic             o_done
);

   logic             osc_prev_q;
   logic [CNT_W-1:0] cnt_q;
   logic             osc_edge;

   // Both edges counted so a half-cycle wait is exact
   assign osc_edge = i_osc ^ osc_prev_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         osc_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= i_osc;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q  <= '0;
         o_done <= 1'b0;
      end else if (!i_enable) begin
         cnt_q  <= '0;
         o_done <= 1'b0;
      end else if (osc_edge && !o_done) begin
         cnt_q  <= cnt_q + 1'b1;
         o_done <= ((cnt_q + 1'b1) == i_target);
      end
   end

   done_after_count_a: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $rose(o_done) |-> ($past(cnt_q) == i_target - 1'b1) && $past(i_enable))
      else $error("settle done without full count");

endmodule

// ---- bench/tb_option_byte_config_decode.sv ----
/*
 * Self-checking bench for the option byte configuration decoder.
 * Assumes the design answers APB with one wait state and captures
 * the option bytes at the first edge after reset release.
 */
`timescale 1ns/1ns
module tb_option_byte_config_decode
   import obcd_pkg::*;
;
   // ****************************************************
   // Signals
   // ****************************************************
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              psel = 1'b0;
   logic              pen = 1'b0;
   logic              pwr = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwd = '0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [7:0]        opt_rm = 8'h00;
   logic [7:0]        opt_cw = 8'h00;
   logic [7:0]        opt_cs = 8'h00;
   logic              ext_osc = 1'b0;
   logic              xtal;
   logic              byp;
   logic              rdy;
   logic              wk_ext;
   logic [13:0]       khz;
   logic [9:0]        pins;
   int                mismatches = 0;
   int                compares = 0;

   always #5 clk = ~clk;

   obcd_top dut_u (.I_CORE_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_OPT_PIN_REMAP(opt_rm), .I_OPT_CLOCK_WAKEUP(opt_cw), .I_OPT_CRYSTAL_SETTLE(opt_cs),
      .I_EXT_HIGH_SPEED_OSC(ext_osc), .O_XTAL_DRIVE_EN(xtal), .O_OSC_BYPASS(byp), .O_OSC_READY(rdy),
      .O_WAKEUP_SRC_EXT(wk_ext), .O_WAKEUP_SRC_KHZ(khz),
      .O_PC3_ADV_TIMER_CH1_COMPLEMENT(pins[9]), .O_PC4_ADV_TIMER_CH2_COMPLEMENT(pins[8]),
      .O_PD7_ADV_TIMER_CHANNEL_FOUR(pins[7]), .O_PD0_MAIN_CLOCK_OUTPUT(pins[6]),
      .O_PB4_CONVERTER_EXT_TRIGGER(pins[5]), .O_PB5_ADV_TIMER_BREAK_INPUT(pins[4]),
      .O_TOP_LEVEL_IRQ_INPUT(pins[3]), .O_PC4_ANALOG_INPUT_TWO(pins[2]),
      .O_PD2_ANALOG_INPUT_THREE(pins[1]), .O_PD4_SERIAL_SYNC_CLOCK(pins[0]));

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic complete_run();
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Idle cycle after each transfer keeps psel from being driven twice at one edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         complete_run();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   // Checked at the second edge: the first reset only takes hold at the first edge
   task automatic do_reset(input logic [7:0] rm, input logic [7:0] cw, input logic [7:0] cs);
      rst <= 1'b1;
      opt_rm <= rm;
      opt_cw <= cw;
      opt_cs <= cs;
      cyc(2);
      chk({18'h0, khz}, {18'h0, WAKEUP_KHZ_16M});
      chk({pins, xtal, byp, rdy, wk_ext}, 32'h0);
      rst <= 1'b0;
      cyc(3);
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   // Every clock/wakeup pattern, every remap bit alone, then input change after capture
   task automatic decode_all();
      logic [31:0] rd;
      logic        er;
      logic [7:0]  r;
      logic [9:0]  ep;
      logic [13:0] ek;
      for (int k = 0; k < 16; k++) begin
         r = 8'h01 << (k % 8);
         do_reset(r, k[7:0], 8'hb4);
         ep = {r[7], r[7], r[6], r[5], r[4], r[4], r[3], r[2], r[2], r[2]};
         ek = (k[1] == 1'b0) ? WAKEUP_KHZ_16M : (k[0] ? WAKEUP_KHZ_4M : WAKEUP_KHZ_8M);
         chk({22'h0, pins}, {22'h0, ep});
         chk({31'h0, byp}, {31'h0, k[3]});
         chk({31'h0, wk_ext}, {31'h0, k[2]});
         chk({18'h0, khz}, {18'h0, ek});
         apb(1'b0, OFS_PIN_REMAP, 32'h0, rd, er);
         chk(rd, {24'h0, r});
         apb(1'b0, OFS_CLOCK_WAKEUP, 32'h0, rd, er);
         chk(rd, k);
         opt_rm <= ~r;
         opt_cw <= ~k[7:0];
         cyc(3);
         chk({22'h0, pins}, {22'h0, ep});
         chk({31'h0, byp}, {31'h0, k[3]});
      end
   endtask

   // Unmapped address and write to a read-only byte
   task automatic bus_refusals();
      logic [31:0] rd;
      logic        er;
      do_reset(8'h10, 8'h00, 8'hd2);
      apb(1'b0, 12'h020, 32'h0, rd, er);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b1, OFS_PIN_REMAP, 32'h0000_00ff, rd, er);
      chk({31'h0, er}, 32'h0);
      apb(1'b0, OFS_PIN_REMAP, 32'h0, rd, er);
      chk(rd, 32'h10);
      apb(1'b0, OFS_CRYSTAL_SETTLE, 32'h0, rd, er);
      chk(rd, 32'hd2);
   endtask

   // Ready must stay low one edge short of the count and rise within six cycles of the last
   task automatic settle(input logic [7:0] code, input int edges);
      logic [31:0] rd;
      logic        er;
      int          n;
      do_reset(8'h00, 8'h00, code);
      apb(1'b1, OFS_CONTROL, 32'h1, rd, er);
      for (n = 0; n < edges - 1; n++) begin
         ext_osc <= ~ext_osc;
         cyc(2);
      end
      cyc(4);
      chk({31'h0, rdy}, 32'h0);
      chk({31'h0, xtal}, 32'h1);
      ext_osc <= ~ext_osc;
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (rdy !== 1'b1 && n < 6);
      chk({31'h0, rdy}, 32'h1);
      if (rdy !== 1'b1) begin
         complete_run();
      end
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      chk({28'h0, rd[3:0]}, {28'h0, !(code inside {8'h00, 8'hb4, 8'hd2, 8'he1}), 3'b011});
      apb(1'b1, OFS_CONTROL, 32'h0, rd, er);
      cyc(3);
      chk({31'h0, rdy}, 32'h0);
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      decode_all();
      bus_refusals();
      settle(SETTLE_CODE_HALF, 1);
      settle(SETTLE_CODE_8, 16);
      settle(SETTLE_CODE_128, 256);
      settle(SETTLE_CODE_2048, 4096);
      settle(8'h55, 4096);
      complete_run();
   end
endmodule
